/* File: src/ppl_pkg.sv */
// Package: shared types and constants of the parallel programming loader
package ppl_pkg;

   // -----------------------------------------------------------------
   // Action-select codes and command bytes
   // -----------------------------------------------------------------
   localparam logic [1:0] ACT_ADDR      = 2'h0;
   localparam logic [1:0] ACT_DATA      = 2'h1;
   localparam logic [1:0] ACT_CMD       = 2'h2;
   localparam logic [7:0] CMD_NOP       = 8'h00;
   localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
   localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
   localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
   localparam logic [7:0] CMD_RD_SIG    = 8'h08;
   localparam logic [7:0] CMD_ERASE     = 8'h80;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ          = 200;
   localparam int BUSY_LOW_MAX_NS  = 1000;
   localparam int WRITE_MIN_US_X10 = 37;
   localparam int WRITE_MAX_US_X10 = 45;
   localparam int ERASE_MIN_US_X10 = 75;
   localparam int ERASE_MAX_US_X10 = 90;
   // Program time aimed at the middle of each window (units of 100 us)
   localparam int WRITE_CYC = (WRITE_MIN_US_X10 + WRITE_MAX_US_X10) * 50 * CLK_MHZ;
   localparam int ERASE_CYC = (ERASE_MIN_US_X10 + ERASE_MAX_US_X10) * 50 * CLK_MHZ;
   // Busy goes low within this many cycles of the strobe edge
   localparam int BUSY_LOW_CYC = BUSY_LOW_MAX_NS * CLK_MHZ / 1000;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] FUSE_LO_RST = 8'hFF;
   localparam logic [7:0] FUSE_HI_RST = 8'hFF;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE, OP_FLASH, OP_EEPROM, OP_FUSE_LO, OP_FUSE_HI, OP_ERASE
   } ppl_op_t;

   // Control pins as sampled
   typedef struct packed {
      logic       action_select_hi;
      logic       action_select_lo;
      logic       byte_select;
      logic       byte_select_ext;
      logic       load_strobe;
      logic       page_latch_strobe;
      logic       write_n;
      logic       out_en_n;
   } ppl_ctl_t;

   // Request to the nonvolatile array
   typedef struct packed {
      ppl_op_t     op;
      logic [15:0] addr;
   } ppl_req_t;

endpackage : ppl_pkg

/* File: src/ppl_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ppl_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A change counts once stages two and three agree
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            pin_out[i] <= 1'b0;
         end else if (s2_r[i] == s3_r[i]) begin
            pin_out[i] <= s3_r[i];
         end
      end
   end
endmodule : ppl_sync

/* File: src/ppl_loader.sv */
// Parallel programming loader: command, address and data capture, page buffer, busy timing
`timescale 1ns/1ps

// Function
// - Action 10, select low: strobe loads command
// - Action 00: strobe loads low/high address
// - Action 01: strobe loads low/high data
// - Command 0x10 enables flash page writing
// - Latch strobe stores data word in buffer
// - Low address bits pick word, rest page
// - Write strobe starts flash page program, busy
// - Command 0x00 clears write enable
// - Command 0x11 selects EEPROM page writing
// - Write strobe programs EEPROM page, busy low
// - Fuse command: zero programs, one erases
// - High fuse written with select 1, ext 0
// - Signature byte read by low address
// - Calibration byte read with select high
// - Busy low within one microsecond of strobe
// - Writes finish between 3.7 and 4.5 ms
// - Erase finishes between 7.5 and 9 ms
// - Command and address persist across operations
// - Command 0x80 plus write strobe erases chip
module ppl_loader #(
   parameter int          PAGE_WORDS = 32,
   parameter int          EE_PAGE    = 4,
   parameter int          WRITE_CYCLES = ppl_pkg::WRITE_CYC,
   parameter int          ERASE_CYCLES = ppl_pkg::ERASE_CYC,
   parameter logic [23:0] SIGNATURE  = 24'h123456,  // Arbitrary identity value
   parameter logic [7:0]  CALIB_BYTE = 8'h80
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              prog_mode,
   input  wire ppl_pkg::ppl_ctl_t ctl_pin,
   input  wire logic [7:0]        data_in,
   output logic      [7:0]        data_out,
   output logic                   data_oe,
   output logic                   ready_busy,
   output ppl_pkg::ppl_req_t      nvm_req,
   output logic                   nvm_start,
   output logic      [15:0]       nvm_word,
   output logic      [7:0]        fuse_lo,
   output logic      [7:0]        fuse_hi
);
   localparam int WBITS = $clog2(PAGE_WORDS);
   localparam int CW    = $clog2(ERASE_CYCLES + 1);

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   initial begin
      if (PAGE_WORDS < 2 || PAGE_WORDS > 256 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0) begin
         $error("PAGE_WORDS must be a power of two from 2 to 256");
      end
      if (EE_PAGE < 1 || EE_PAGE > PAGE_WORDS) begin
         $error("EE_PAGE out of range");
      end
      // Busy must stand at least two cycles so the start pulse sees it low
      if (WRITE_CYCLES < 2 || ERASE_CYCLES < WRITE_CYCLES) begin
         $error("Program cycle counts invalid");
      end
      // Pin to busy takes five cycles through synchroniser and edge detect
      // so the busy answer deadline cannot be shorter than that
      if (ppl_pkg::BUSY_LOW_CYC < 6) begin
         $error("Busy answer deadline too short");
      end
   end

   // -----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // -----------------------------------------------------------------
   ppl_pkg::ppl_ctl_t ctl_s;
   logic [7:0]        data_s;
   ppl_pkg::ppl_ctl_t ctl_d_r;

   ppl_sync #(.W(16)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  ({ctl_pin, data_in}),
      .pin_out ({ctl_s, data_s})
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctl_d_r <= '0;
      end else begin
         ctl_d_r <= ctl_s;
      end
   end

   logic busy;
   logic active;
   logic load_rise;
   logic latch_rise;
   logic wr_fall;
   logic [1:0] act;

   assign busy       = !ready_busy;
   assign active     = prog_mode && !busy;
   assign load_rise  = active && ctl_s.load_strobe && !ctl_d_r.load_strobe;
   assign latch_rise = active && ctl_s.page_latch_strobe && !ctl_d_r.page_latch_strobe;
   assign wr_fall    = active && !ctl_s.write_n && ctl_d_r.write_n;
   assign act        = {ctl_s.action_select_hi, ctl_s.action_select_lo};

   // -----------------------------------------------------------------
   // Command, address and data latches
   // -----------------------------------------------------------------
   logic [7:0] cmd_r;
   logic [7:0] addr_lo_r;
   logic [7:0] addr_hi_r;
   logic [7:0] dat_lo_r;
   logic [7:0] dat_hi_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cmd_r <= ppl_pkg::CMD_NOP;
      end else if (load_rise && act == ppl_pkg::ACT_CMD && !ctl_s.byte_select) begin
         cmd_r <= data_s;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         addr_lo_r <= 8'h00;
         addr_hi_r <= 8'h00;
      end else if (load_rise && act == ppl_pkg::ACT_ADDR) begin
         if (ctl_s.byte_select) begin
            addr_hi_r <= data_s;
         end else begin
            addr_lo_r <= data_s;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dat_lo_r <= 8'h00;
         dat_hi_r <= 8'h00;
      end else if (load_rise && act == ppl_pkg::ACT_DATA) begin
         if (ctl_s.byte_select) begin
            dat_hi_r <= data_s;
         end else begin
            dat_lo_r <= data_s;
         end
      end
   end

   // -----------------------------------------------------------------
   // Write enable
   // -----------------------------------------------------------------
   // Write enable: set by any command other than no-operation, cleared by the no-operation command
   logic wen_r;
   logic cmd_load;
   assign cmd_load = load_rise && act == ppl_pkg::ACT_CMD && !ctl_s.byte_select;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wen_r <= 1'b0;
      end else if (cmd_load) begin
         wen_r <= data_s != ppl_pkg::CMD_NOP;
      end
   end

   // -----------------------------------------------------------------
   // Page buffer
   // -----------------------------------------------------------------
   logic [15:0]      page_buf [PAGE_WORDS];
   logic [WBITS-1:0] word_sel;
   logic             buf_we;

   assign word_sel = addr_lo_r[WBITS-1:0];
   // EEPROM and flash commands both latch the full word; byte select must be high
   assign buf_we   = latch_rise && ctl_s.byte_select && wen_r &&
                     (cmd_r == ppl_pkg::CMD_WR_FLASH || cmd_r == ppl_pkg::CMD_WR_EEPROM);

   always_ff @(posedge clk_sys) begin
      if (buf_we) begin
         page_buf[word_sel] <= {dat_hi_r, dat_lo_r};
      end
   end

   // Array port walks the buffer while busy
   logic [WBITS-1:0] rd_idx_r;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_idx_r <= '0;
         nvm_word <= 16'h0000;
      end else begin
         nvm_word <= page_buf[rd_idx_r];
         rd_idx_r <= busy ? WBITS'(rd_idx_r + 1'b1) : '0;
      end
   end

   // -----------------------------------------------------------------
   // Write strobe decode and busy timer
   // -----------------------------------------------------------------
   ppl_pkg::ppl_op_t op;
   always_comb begin
      op = ppl_pkg::OP_NONE;
      if (wr_fall && !ctl_s.byte_select && wen_r) begin
         unique case (cmd_r)
            ppl_pkg::CMD_WR_FLASH:  op = ppl_pkg::OP_FLASH;
            ppl_pkg::CMD_WR_EEPROM: op = ppl_pkg::OP_EEPROM;
            ppl_pkg::CMD_ERASE:     op = ppl_pkg::OP_ERASE;
            ppl_pkg::CMD_WR_FUSE:   op = ppl_pkg::OP_FUSE_LO;
            default:                op = ppl_pkg::OP_NONE;
         endcase
      end else if (wr_fall && ctl_s.byte_select && !ctl_s.byte_select_ext && wen_r &&
                   cmd_r == ppl_pkg::CMD_WR_FUSE) begin
         op = ppl_pkg::OP_FUSE_HI;
      end
   end

   // Page number keeps the top low-address bits; word bits are cleared
   logic [15:0] page_addr;
   assign page_addr = {addr_hi_r, addr_lo_r} & ~16'(PAGE_WORDS - 1);

   // Array request: one start pulse and the page it covers
   // The request stands unchanged until the next start
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         nvm_start <= 1'b0;
         nvm_req   <= '0;
      end else begin
         nvm_start <= op != ppl_pkg::OP_NONE;
         if (op != ppl_pkg::OP_NONE) begin
            nvm_req.op   <= op;
            nvm_req.addr <= page_addr;
         end
      end
   end

   logic [CW-1:0] cnt_r;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_r      <= '0;
         ready_busy <= 1'b1;
      end else begin
         if (op != ppl_pkg::OP_NONE) begin
            ready_busy <= 1'b0;
            cnt_r <= (op == ppl_pkg::OP_ERASE) ? CW'(ERASE_CYCLES - 1)
                                               : CW'(WRITE_CYCLES - 1);
         end else if (busy) begin
            if (cnt_r == '0) begin
               ready_busy <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Fuse bytes
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fuse_lo <= ppl_pkg::FUSE_LO_RST;
         fuse_hi <= ppl_pkg::FUSE_HI_RST;
      end else if (op == ppl_pkg::OP_FUSE_LO) begin
         fuse_lo <= dat_lo_r;
      end else if (op == ppl_pkg::OP_FUSE_HI) begin
         fuse_hi <= dat_lo_r;
      end
   end

   // -----------------------------------------------------------------
   // Read-back of signature and calibration
   // -----------------------------------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (ctl_s.byte_select) begin
         rd_byte = CALIB_BYTE;
      end else begin
         unique case (addr_lo_r)
            8'h00:   rd_byte = SIGNATURE[23:16];
            8'h01:   rd_byte = SIGNATURE[15:8];
            8'h02:   rd_byte = SIGNATURE[7:0];
            default: rd_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         data_oe  <= 1'b0;
         data_out <= 8'h00;
      end else begin
         data_oe  <= prog_mode && !ctl_s.out_en_n && cmd_r == ppl_pkg::CMD_RD_SIG;
         data_out <= rd_byte;
      end
   end

endmodule : ppl_loader

/* File: tb/ppl_loader_props.sv */
// Checker: port-level properties of the loader
`timescale 1ns/1ps
module ppl_loader_props #(
   parameter int WRITE_CYCLES = 50,
   parameter int ERASE_CYCLES = 100
) (
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              prog_mode,
   input wire ppl_pkg::ppl_ctl_t ctl_pin,
   input wire logic              data_oe,
   input wire logic              ready_busy,
   input wire ppl_pkg::ppl_req_t nvm_req,
   input wire logic              nvm_start
);
   // ----------------------------------------
   // Busy length counter
   // ----------------------------------------
   int low_r;
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         low_r <= 0;
      else if (nvm_start)
         low_r <= 1;
      else if (!ready_busy)
         low_r <= low_r + 1;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_start_busy;
      nvm_start |-> !ready_busy ##1 !ready_busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("busy not low at start");
   property p_fall_cause;
      $fell(ready_busy) |-> nvm_start;
   endproperty
   a_fall_cause: assert property (p_fall_cause) else $error("busy fell without start");
   property p_no_restart;
      !ready_busy |=> !nvm_start;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("start while busy");
   property p_mode_gate;
      !prog_mode |=> !nvm_start;
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("start outside mode");
   property p_write_len;
      $rose(ready_busy) && nvm_req.op != ppl_pkg::OP_ERASE
         |-> low_r inside {[WRITE_CYCLES-2:WRITE_CYCLES+2]};
   endproperty
   a_write_len: assert property (p_write_len) else $error("write busy length");
   property p_erase_len;
      $rose(ready_busy) && nvm_req.op == ppl_pkg::OP_ERASE
         |-> low_r inside {[ERASE_CYCLES-2:ERASE_CYCLES+2]};
   endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase busy length");
   property p_req_hold;
      !ready_busy && !nvm_start |-> $stable(nvm_req);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved while busy");
   property p_oe_release;
      $rose(ctl_pin.out_en_n) |-> ##[1:10] !data_oe;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("bus not released");
   property p_oe_cause;
      $rose(data_oe) |-> !ctl_pin.out_en_n;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("bus driven unasked");
endmodule : ppl_loader_props

bind ppl_loader ppl_loader_props #(
   .WRITE_CYCLES(WRITE_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES)
) u_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .prog_mode(prog_mode), .ctl_pin(ctl_pin),
   .data_oe(data_oe), .ready_busy(ready_busy), .nvm_req(nvm_req), .nvm_start(nvm_start)
);

/* File: tb/ppl_prog_model.sv */
// Programmer model: drives the parallel programming pins
`timescale 1ns/1ps
module ppl_prog_model (
   input  wire logic         clk_sys,
   input  wire logic         ready_busy,
   output ppl_pkg::ppl_ctl_t ctl,
   output logic [7:0]        data
);
   // Idle: action 11, strobes low, write and output enable high
   initial begin
      ctl = 8'hC3;
      data = 8'h00;
   end
   // Released bus shows a pattern that changes every cycle
   always @(posedge clk_sys)
      if (!ctl.out_en_n)
         data <= ~data;
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : step
   task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
      @(posedge clk_sys);
      {ctl.action_select_hi, ctl.action_select_lo} <= act;
      ctl.byte_select <= bs;
      data <= d;
      step(8);
      ctl.load_strobe <= 1'b1;
      step(10);
      ctl.load_strobe <= 1'b0;
      step(8);
   endtask : load
   task automatic latch;
      @(posedge clk_sys);
      ctl.byte_select <= 1'b1;
      step(8);
      ctl.page_latch_strobe <= 1'b1;
      step(10);
      ctl.page_latch_strobe <= 1'b0;
      step(8);
   endtask : latch
   task automatic wr(input logic bs, input logic ext);
      @(posedge clk_sys);
      ctl.byte_select <= bs;
      ctl.byte_select_ext <= ext;
      step(8);
      ctl.write_n <= 1'b0;
      step(10);
      ctl.write_n <= 1'b1;
      step(2);
   endtask : wr
   task automatic oe(input logic v, input logic bs);
      @(posedge clk_sys);
      ctl.byte_select <= bs;
      ctl.out_en_n <= v;
      step(12);
   endtask : oe
   task automatic wait_rdy;
      int n;
      n = 0;
      while (ready_busy !== 1'b1 && n < 1000) begin
         step(1);
         n++;
      end
      step(4);
   endtask : wait_rdy
endmodule : ppl_prog_model

/* File: tb/parallel_prog_loader_tb.sv */
// Testbench: programming sequences through the loader pins
`timescale 1ns/1ps
module parallel_prog_loader_tb;
   localparam int          WR_C = 50;
   localparam int          ER_C = 100;
   localparam logic [23:0] SIG  = 24'hA1B2C3; // Arbitrary identity value
   localparam logic [7:0]  CAL  = 8'h6E;
   logic clk_sys, rst_n, prog_mode, data_oe, ready_busy, nvm_start, word_hit;
   logic [7:0] data_out, pm_data, fuse_lo, fuse_hi;
   logic [15:0] nvm_word, word_exp;
   ppl_pkg::ppl_ctl_t ctl;
   ppl_pkg::ppl_req_t req;
   int fails, check_count, starts, lo_cnt, last_len;

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   ppl_prog_model pm (.clk_sys(clk_sys), .ready_busy(ready_busy), .ctl(ctl), .data(pm_data));
   ppl_loader #(.WRITE_CYCLES(WR_C), .ERASE_CYCLES(ER_C), .SIGNATURE(SIG), .CALIB_BYTE(CAL)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .prog_mode(prog_mode), .ctl_pin(ctl),
      .data_in(data_oe ? data_out : pm_data), .data_out(data_out), .data_oe(data_oe),
      .ready_busy(ready_busy), .nvm_req(req), .nvm_start(nvm_start), .nvm_word(nvm_word),
      .fuse_lo(fuse_lo), .fuse_hi(fuse_hi));
   // Start count, busy length and streamed word watch
   always @(posedge clk_sys) begin
      if (nvm_start === 1'b1)
         starts++;
      if (ready_busy === 1'b0) begin
         lo_cnt++;
         if (nvm_word === word_exp)
            word_hit = 1'b1;
      end else if (lo_cnt != 0) begin
         last_len = lo_cnt;
         lo_cnt = 0;
      end
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic len(input int n);
      chk(24'(last_len >= n - 2 && last_len <= n + 2), 24'h1);
   endtask : len
   task automatic t_flash;
      pm.load(ppl_pkg::ACT_CMD, 1'b0, ppl_pkg::CMD_WR_FLASH);
      pm.load(ppl_pkg::ACT_ADDR, 1'b0, 8'h25);
      pm.load(ppl_pkg::ACT_DATA, 1'b0, 8'hA5);
      pm.load(ppl_pkg::ACT_DATA, 1'b1, 8'h3C);
      pm.latch();
      pm.load(ppl_pkg::ACT_ADDR, 1'b1, 8'h12);
      word_exp = 16'h3CA5;
      word_hit = 1'b0;
      starts = 0;
      pm.wr(1'b0, 1'b0);
      chk(24'(ready_busy), 24'h0);
      chk(24'(req), 24'({ppl_pkg::OP_FLASH, 16'h1220}));
      pm.wr(1'b0, 1'b0);
      pm.wait_rdy();
      chk(24'(starts), 24'h1);
      chk(24'(word_hit), 24'h1);
      len(WR_C);
      pm.wr(1'b0, 1'b0);
      pm.wait_rdy();
      chk(24'(starts), 24'h2);
      chk(24'(req), 24'({ppl_pkg::OP_FLASH, 16'h1220}));
      $display("flash test done");
   endtask : t_flash
   task automatic t_nop;
      pm.load(ppl_pkg::ACT_CMD, 1'b0, ppl_pkg::CMD_NOP);
      starts = 0;
      pm.wr(1'b0, 1'b0);
      pm.step(10);
      chk(24'(starts), 24'h0);
      $display("nop test done");
   endtask : t_nop
   task automatic t_ee;
      pm.load(ppl_pkg::ACT_CMD, 1'b0, ppl_pkg::CMD_WR_EEPROM);
      pm.load(ppl_pkg::ACT_ADDR, 1'b1, 8'h00);
      pm.load(ppl_pkg::ACT_ADDR, 1'b0, 8'h03);
      pm.load(ppl_pkg::ACT_DATA, 1'b0, 8'h77);
      pm.latch();
      pm.wr(1'b0, 1'b0);
      chk(24'(ready_busy), 24'h0);
      chk(24'(req), 24'({ppl_pkg::OP_EEPROM, 16'h0000}));
      pm.wait_rdy();
      $display("eeprom test done");
   endtask : t_ee
   task automatic t_fuse;
      pm.load(ppl_pkg::ACT_CMD, 1'b0, ppl_pkg::CMD_WR_FUSE);
      pm.load(ppl_pkg::ACT_DATA, 1'b0, 8'h5A);
      pm.wr(1'b0, 1'b0);
      pm.wait_rdy();
      chk(24'(fuse_lo), 24'h5A);
      pm.wr(1'b1, 1'b0);
      pm.wait_rdy();
      chk(24'(fuse_hi), 24'h5A);
      chk(24'(req.op), 24'(ppl_pkg::OP_FUSE_HI));
      $display("fuse test done");
   endtask : t_fuse
   task automatic t_erase;
      pm.load(ppl_pkg::ACT_CMD, 1'b0, ppl_pkg::CMD_ERASE);
      pm.wr(1'b0, 1'b0);
      chk(24'(req.op), 24'(ppl_pkg::OP_ERASE));
      pm.wait_rdy();
      len(ER_C);
      $display("erase test done");
   endtask : t_erase
   task automatic t_off;
      @(posedge clk_sys);
      prog_mode <= 1'b0;
      starts = 0;
      pm.wr(1'b0, 1'b0);
      pm.step(10);
      chk(24'(starts), 24'h0);
      prog_mode <= 1'b1;
      $display("mode test done");
   endtask : t_off
   task automatic t_read;
      pm.load(ppl_pkg::ACT_CMD, 1'b0, ppl_pkg::CMD_RD_SIG);
      for (int i = 0; i < 3; i++) begin
         pm.load(ppl_pkg::ACT_ADDR, 1'b0, 8'(i));
         pm.oe(1'b0, 1'b0);
         chk({16'h0, data_oe, data_out[7:1]}, {16'h0, 1'b1, SIG[23-8*i -: 7]});
         chk(24'(data_out[0]), 24'(SIG[16-8*i]));
         pm.oe(1'b1, 1'b0);
         chk(24'(data_oe), 24'h0);
      end
      pm.load(ppl_pkg::ACT_ADDR, 1'b0, 8'h00);
      pm.oe(1'b0, 1'b1);
      chk(24'(data_out), 24'(CAL));
      pm.oe(1'b1, 1'b0);
      $display("read test done");
   endtask : t_read
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      prog_mode = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      prog_mode <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(24'(ready_busy), 24'h1);
      t_flash();
      t_nop();
      t_ee();
      t_fuse();
      t_erase();
      t_off();
      t_read();
      wrap_up();
   end
endmodule : parallel_prog_loader_tb
